//--- shared/fit_pkg.sv
// Package for the fast instruction timing decoder.
// Assumes a single system clock domain and an AXI4-Lite register master.
package fit_pkg;

    // ************************************************************
    // Register byte offsets on the register bus.
    // ************************************************************
    localparam logic [7:0] OFF_MAIN_OPERAND  = 8'he0; // Main operand register.
    localparam logic [7:0] OFF_MULDIV_OPND   = 8'hf0; // Multiply/divide operand register.
    localparam logic [7:0] OFF_OPCODE        = 8'h00; // Opcode presented for decode.
    localparam logic [7:0] OFF_COND          = 8'h04; // Branch condition outcome.
    localparam logic [7:0] OFF_DECODE        = 8'h08; // Decode result, read only.
    localparam logic [7:0] OFF_COUNT         = 8'h0c; // Decode counter, read only.

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [7:0] RST_MAIN_OPERAND  = 8'h00; // Main operand reset value.
    localparam logic [7:0] RST_MULDIV_OPND   = 8'h00; // Multiply/divide reset value.
    localparam logic [7:0] RST_OPCODE        = 8'h00; // Opcode reset value.

    // ************************************************************
    // Decode result field positions.
    // ************************************************************
    localparam int POS_LEN    = 0;  // Length in bytes, bits 1:0.
    localparam int POS_CYC    = 4;  // Cycle count, bits 7:4.
    localparam int POS_REG    = 8;  // Working register number, bits 10:8.
    localparam int POS_REGV   = 11; // Register field valid.
    localparam int POS_PAGE   = 12; // Absolute page, bits 14:12.
    localparam int POS_ABS    = 15; // Absolute jump or call.
    localparam int POS_COND   = 16; // Conditional branch.
    localparam int POS_CLRBIT = 17; // Bit clear on taken branch.
    localparam int POS_FORM   = 20; // Operand form, bits 22:20.

    // ************************************************************
    // Cycle counts.
    // ************************************************************
    localparam logic [3:0] CYC_2 = 4'h2; // Short operation.
    localparam logic [3:0] CYC_4 = 4'h4; // Medium operation or branch not taken.
    localparam logic [3:0] CYC_6 = 4'h6; // Jump or branch taken.
    localparam logic [3:0] CYC_8 = 4'h8; // Table read, external transfer, multiply.

    // Operand forms.
    typedef enum logic [2:0] {
        FORM_NONE, FORM_REG, FORM_DIR, FORM_IND, FORM_IMM, FORM_REL
    } fit_form_e;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer.
    localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

endpackage

//--- design/fit_decoder.sv
// Instruction length, operand form and timing decoder with register slave.
// Assumes an AXI4-Lite master on the same 20 MHz clock and synchronous reset.
`timescale 1ns/10ps

// Operation
// - Length one to three, two to eight cycles.
// - Register number from lowest opcode bits.
// - Absolute page from top opcode bits.
// - Add with carry opcodes, two cycles.
// - Subtract with borrow opcodes, two cycles.
// - Pointer increment four cycles, others two.
// - Logic into accumulator, two cycles.
// - Logic immediate into direct, three bytes, four.
// - Rotates one byte, two cycles.
// - Register direct moves take four cycles.
// - Pointer load three bytes, four cycles.
// - Table reads take eight cycles.
// - External transfers take eight cycles.
// - Push and pop two bytes, four.
// - Nibble exchange two cycles.
// - Bit logic into carry four cycles.
// - Carry to bit four, bit to two.
// - Calls, returns, jumps take six cycles.
// - Conditional branches take four or six.
// - Decrement branch two or three bytes.
// - Test clear branch is three bytes.
module fit_decoder (
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic [7:0]  S_AXI_AWADDR_IN,
    input  wire logic        S_AXI_AWVALID_IN,
    output logic             S_AXI_AWREADY_OUT,
    input  wire logic [31:0] S_AXI_WDATA_IN,
    input  wire logic [3:0]  S_AXI_WSTRB_IN,
    input  wire logic        S_AXI_WVALID_IN,
    output logic             S_AXI_WREADY_OUT,
    output logic [1:0]       S_AXI_BRESP_OUT,
    output logic             S_AXI_BVALID_OUT,
    input  wire logic        S_AXI_BREADY_IN,
    input  wire logic [7:0]  S_AXI_ARADDR_IN,
    input  wire logic        S_AXI_ARVALID_IN,
    output logic             S_AXI_ARREADY_OUT,
    output logic [31:0]      S_AXI_RDATA_OUT,
    output logic [1:0]       S_AXI_RRESP_OUT,
    output logic             S_AXI_RVALID_OUT,
    input  wire logic        S_AXI_RREADY_IN,
    output logic [3:0]       CYCLES_OUT,
    output logic [1:0]       LENGTH_OUT
);

    // ************************************************************
    // Register storage.
    // ************************************************************
    logic [7:0]  main_operand_ff;   // Main operand register.
    logic [7:0]  muldiv_opnd_ff;    // Multiply/divide operand register.
    logic [7:0]  opcode_ff;         // Opcode under decode.
    logic        taken_ff;          // Branch outcome for timing.
    logic [15:0] count_ff;          // Number of opcode writes.
    logic [3:0]  cycles_ff;         // Registered cycle output.
    logic [1:0]  length_ff;         // Registered length output.
    logic        awready_ff;        // Address ready flop; also gates address acceptance.
    logic        wready_ff;         // Data ready flop; also gates data acceptance.
    logic        arready_ff;        // Read address ready flop; also gates read acceptance.

    // ************************************************************
    // Combinational decode of the held opcode.
    // ************************************************************
    logic [1:0]  dec_len;           // Length in bytes.
    logic [3:0]  dec_cyc;           // Cycle count.
    logic [2:0]  dec_form;          // Operand form.
    logic        dec_cond;          // Conditional branch.
    logic        dec_clr;           // Clears the tested bit.
    wire  [7:0]  op       = opcode_ff;
    wire  [3:0]  lo       = op[3:0];
    wire  [3:0]  hi       = op[7:4];
    wire         is_regf  = op[3];
    wire  [2:0]  reg_num  = op[2:0];
    wire         is_abs   = (op[4:0] == 5'h01) || (op[4:0] == 5'h11);
    wire  [2:0]  abs_page = op[7:5];
    wire  [3:0]  br_cyc   = taken_ff ? fit_pkg::CYC_6 : fit_pkg::CYC_4;

    // The table is written by column, then rows override; this keeps it short
    // while still covering every opcode of the instruction set.
    always_comb begin
        dec_len  = 2'd1;
        dec_cyc  = fit_pkg::CYC_2;
        dec_form = fit_pkg::FORM_NONE;
        dec_cond = 1'b0;
        dec_clr  = 1'b0;
        if (is_regf) begin
            // Register column: two cycles unless noted.
            dec_form = fit_pkg::FORM_REG;
            unique case (hi)
                4'h7, 4'hd: dec_len = 2'd2;
                4'ha, 4'h8: begin
                    dec_len = 2'd2;
                    dec_cyc = fit_pkg::CYC_4;
                end
                4'hb: begin
                    dec_len = 2'd3;
                    dec_form = fit_pkg::FORM_REL;
                end
                default: dec_len = 2'd1;
            endcase
            if (hi == 4'hb || hi == 4'hd) begin
                dec_cond = 1'b1;
                dec_cyc  = br_cyc;
            end
        end else if (lo == 4'h6 || lo == 4'h7) begin
            // Indirect column, one byte and two cycles by default.
            dec_form = fit_pkg::FORM_IND;
            unique case (hi)
                4'h7: dec_len = 2'd2;
                4'h8, 4'ha: begin
                    dec_len = 2'd2;
                    dec_cyc = fit_pkg::CYC_4;
                end
                4'hb: begin
                    dec_len  = 2'd3;
                    dec_cond = 1'b1;
                    dec_cyc  = br_cyc;
                end
                default: dec_len = 2'd1;
            endcase
        end else if (is_abs) begin
            dec_len  = 2'd2;
            dec_cyc  = fit_pkg::CYC_6;
            dec_form = fit_pkg::FORM_DIR;
        end else begin
            unique case (op)
                8'h00, 8'h03, 8'h13, 8'h23, 8'h33,
                8'h04, 8'h14, 8'hc3, 8'hd3, 8'hb3,
                8'hc4, 8'hd4, 8'he4, 8'hf4: dec_len = 2'd1;
                8'h24, 8'h34, 8'h94, 8'h44, 8'h54, 8'h64, 8'h74: begin
                    dec_len  = 2'd2;
                    dec_form = fit_pkg::FORM_IMM;
                end
                8'h25, 8'h35, 8'h95, 8'h45, 8'h55, 8'h65, 8'h05, 8'h15,
                8'h42, 8'h52, 8'h62, 8'hc2, 8'hd2, 8'hb2, 8'ha2,
                8'hc5, 8'he5, 8'hf5: begin
                    dec_len  = 2'd2;
                    dec_form = fit_pkg::FORM_DIR;
                end
                8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin
                    dec_len  = 2'd3;
                    dec_cyc  = fit_pkg::CYC_4;
                    dec_form = fit_pkg::FORM_DIR;
                end
                8'ha3: dec_cyc = fit_pkg::CYC_4;
                8'h90: begin
                    dec_len  = 2'd3;
                    dec_cyc  = fit_pkg::CYC_4;
                    dec_form = fit_pkg::FORM_IMM;
                end
                8'h82, 8'hb0, 8'h72, 8'ha0, 8'h92, 8'hc0, 8'hd0: begin
                    dec_len  = 2'd2;
                    dec_cyc  = fit_pkg::CYC_4;
                    dec_form = fit_pkg::FORM_DIR;
                end
                8'h93, 8'h83, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3,
                8'ha4, 8'h84: dec_cyc = fit_pkg::CYC_8;
                8'h22, 8'h32, 8'h73: dec_cyc = fit_pkg::CYC_6;
                8'h12, 8'h02: begin
                    dec_len  = 2'd3;
                    dec_cyc  = fit_pkg::CYC_6;
                    dec_form = fit_pkg::FORM_IMM;
                end
                8'h80: begin
                    dec_len  = 2'd2;
                    dec_cyc  = fit_pkg::CYC_6;
                    dec_form = fit_pkg::FORM_REL;
                end
                8'h40, 8'h50, 8'h60, 8'h70: begin
                    dec_len  = 2'd2;
                    dec_cond = 1'b1;
                    dec_cyc  = br_cyc;
                    dec_form = fit_pkg::FORM_REL;
                end
                8'h10, 8'h20, 8'h30, 8'hb4, 8'hb5, 8'hd5: begin
                    dec_len  = 2'd3;
                    dec_cond = 1'b1;
                    dec_clr  = (op == 8'h10);
                    dec_cyc  = br_cyc;
                    dec_form = fit_pkg::FORM_REL;
                end
                default: dec_len = 2'd1;                         // Unused code A5.
            endcase
        end
    end

    // Packed decode word as software sees it.
    wire [31:0] decode_word = {9'h000, dec_form, 2'b00, dec_clr, dec_cond, is_abs,
                               abs_page, is_regf, reg_num, dec_cyc, 2'b00, dec_len};

    // ************************************************************
    // Write channel: address and data accepted in either order.
    // ************************************************************
    logic        aw_held_ff;        // Write address captured.
    logic [7:0]  aw_addr_ff;        // Captured write address.
    logic        w_held_ff;         // Write data captured.
    logic [31:0] w_data_ff;         // Captured write data.
    logic        w_strb0_ff;        // Low byte lane enable.
    logic        bvalid_ff;         // Write response pending.
    logic [1:0]  bresp_ff;          // Write response code.
    // A channel is taken only at an edge where the master also sees its ready
    // high; taking it on internal state alone would lose or repeat transfers.
    wire         aw_fire  = S_AXI_AWVALID_IN && awready_ff;
    wire         w_fire   = S_AXI_WVALID_IN && wready_ff;
    wire         wr_go    = aw_held_ff && w_held_ff && !bvalid_ff;
    wire         wr_lane  = wr_go && w_strb0_ff;
    wire         wr_mapped = (aw_addr_ff == fit_pkg::OFF_MAIN_OPERAND) ||
                             (aw_addr_ff == fit_pkg::OFF_MULDIV_OPND) ||
                             (aw_addr_ff == fit_pkg::OFF_OPCODE) ||
                             (aw_addr_ff == fit_pkg::OFF_COND);
    wire         wr_op    = wr_lane && (aw_addr_ff == fit_pkg::OFF_OPCODE);

    // Handshake state for the write side; one write is in flight at a time.
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= fit_pkg::RESP_OKAY;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb0_ff <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= {S_AXI_AWADDR_IN[7:2], 2'b00};
            end
            if (w_fire) begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= S_AXI_WDATA_IN;
                w_strb0_ff <= S_AXI_WSTRB_IN[0];
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_mapped ? fit_pkg::RESP_OKAY : fit_pkg::RESP_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY_IN) begin
                bvalid_ff  <= 1'b0;
            end
        end
    end

    // Register updates from completed writes; only byte lane 0 carries data.
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            main_operand_ff <= fit_pkg::RST_MAIN_OPERAND;
            muldiv_opnd_ff  <= fit_pkg::RST_MULDIV_OPND;
            opcode_ff       <= fit_pkg::RST_OPCODE;
            taken_ff        <= 1'b0;
            count_ff        <= 16'h0000;
        end else begin
            if (wr_lane && aw_addr_ff == fit_pkg::OFF_MAIN_OPERAND) begin
                main_operand_ff <= w_data_ff[7:0];
            end
            if (wr_lane && aw_addr_ff == fit_pkg::OFF_MULDIV_OPND) begin
                muldiv_opnd_ff <= w_data_ff[7:0];
            end
            if (wr_op) begin
                opcode_ff <= w_data_ff[7:0];
                count_ff  <= count_ff + 16'h0001;
            end
            if (wr_lane && aw_addr_ff == fit_pkg::OFF_COND) begin
                taken_ff <= w_data_ff[0];
            end
        end
    end

    // Timing outputs follow the decode one cycle later, from flip-flops.
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            cycles_ff <= fit_pkg::CYC_2;
            length_ff <= 2'd1;
        end else begin
            cycles_ff <= dec_cyc;
            length_ff <= dec_len;
        end
    end

    // ************************************************************
    // Read channel: answer one cycle after the address is taken.
    // ************************************************************
    logic        rvalid_ff;         // Read data pending.
    logic [31:0] rdata_ff;          // Read data.
    logic [1:0]  rresp_ff;          // Read response code.
    wire         ar_fire = S_AXI_ARVALID_IN && arready_ff;
    wire  [7:0]  ar_addr = {S_AXI_ARADDR_IN[7:2], 2'b00};
    logic [31:0] rd_mux;            // Selected read value.
    logic        rd_ok;             // Address is mapped.

    // Read selection; unmapped addresses read zero with an error response.
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ar_addr)
            fit_pkg::OFF_MAIN_OPERAND: rd_mux = {24'h000000, main_operand_ff};
            fit_pkg::OFF_MULDIV_OPND:  rd_mux = {24'h000000, muldiv_opnd_ff};
            fit_pkg::OFF_OPCODE:       rd_mux = {24'h000000, opcode_ff};
            fit_pkg::OFF_COND:         rd_mux = {31'h00000000, taken_ff};
            fit_pkg::OFF_DECODE:       rd_mux = decode_word;
            fit_pkg::OFF_COUNT:        rd_mux = {16'h0000, count_ff};
            default:                   rd_ok  = 1'b0;
        endcase
    end

    // Read response register, held until the master takes it.
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= fit_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_mux;
            rresp_ff  <= rd_ok ? fit_pkg::RESP_OKAY : fit_pkg::RESP_SLVERR;
        end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs. Ready signals are registered copies of acceptance state.
    // ************************************************************
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            arready_ff <= 1'b0;
        end else begin
            awready_ff <= !aw_held_ff && !bvalid_ff && !aw_fire && !wr_go;
            wready_ff  <= !w_held_ff && !bvalid_ff && !w_fire && !wr_go;
            arready_ff <= !rvalid_ff && !ar_fire;
        end
    end
    // Acceptance wires must agree with the ready flops seen by the master.
    assign S_AXI_AWREADY_OUT = awready_ff;
    assign S_AXI_WREADY_OUT  = wready_ff;
    assign S_AXI_ARREADY_OUT = arready_ff;
    assign S_AXI_BVALID_OUT  = bvalid_ff;
    assign S_AXI_BRESP_OUT   = bresp_ff;
    assign S_AXI_RVALID_OUT  = rvalid_ff;
    assign S_AXI_RDATA_OUT   = rdata_ff;
    assign S_AXI_RRESP_OUT   = rresp_ff;
    assign CYCLES_OUT        = cycles_ff;
    assign LENGTH_OUT        = length_ff;

    // ************************************************************
    // Assertions.
    // ************************************************************
    a_cyc_range: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        dec_cyc >= 4'd2 && dec_cyc <= 4'd8 && dec_len >= 2'd1)
        else $error("cycle or length out of range");
    a_reg_field: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff[7:3] == 5'h1d |-> decode_word[10:8] == opcode_ff[2:0] && decode_word[11])
        else $error("register number wrong");
    a_abs_page: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff[3:0] == 4'h1 |-> decode_word[14:12] == opcode_ff[7:5] && dec_cyc == 4'd6)
        else $error("absolute page wrong");
    a_add_time: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff[7:4] inside {4'h2, 4'h3, 4'h9} && opcode_ff[3:2] != 2'b00
        |=> CYCLES_OUT == 4'd2)
        else $error("arithmetic timing wrong");
    a_data_pointer_16bit_inc: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff == 8'ha3 |=> CYCLES_OUT == 4'd4 && LENGTH_OUT == 2'd1)
        else $error("pointer increment timing wrong");
    a_logic_dir: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff inside {8'h43, 8'h53, 8'h63, 8'h90} |-> dec_len == 2'd3 && dec_cyc == 4'd4)
        else $error("three byte four cycle decode wrong");
    a_ext_time: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'h93, 8'h83} |-> dec_cyc == 4'd8)
        else $error("eight cycle decode wrong");
    a_branch_time: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        dec_cond && !$changed(opcode_ff) && !$changed(taken_ff)
        |=> CYCLES_OUT == ($past(taken_ff) ? 4'd6 : 4'd4))
        else $error("branch timing wrong");
    a_clr_branch: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        opcode_ff == 8'h10 |-> dec_clr && dec_len == 2'd3)
        else $error("test clear branch decode wrong");

endmodule

//--- tb/fit_prog_rom.sv
// Program memory model: a small table of opcode words fed to the bench.
// Assumes the reader settles the index one clock before using the word.
`timescale 1ns/10ps
// ****************************************
// Table layout: opcode, taken flag, length, cycles.
// ****************************************
module fit_prog_rom (
    input  wire logic [4:0]  addr_in,
    output logic      [19:0] word_out
);
    // Fixed contents; the last entry is the test-and-clear branch.
    localparam logic [19:0] TBL [22] = '{
        20'h28012, 20'h3f012, 20'h94022, 20'ha3014, 20'h53034, 20'h33012,
        20'haf024, 20'h90034, 20'h93018, 20'he2018, 20'hc0024, 20'hd7012,
        20'hb0024, 20'h92024, 20'h12036, 20'hb8034, 20'hb8136, 20'hd5136,
        20'h68012, 20'ha2022, 20'h73016, 20'h10136};
    // Reads are combinational; the bench never drives an index beyond the table.
    assign word_out = TBL[addr_in];
endmodule

//--- tb/tb_fit_decoder.sv
// Bench for the timing decoder: register bus master and opcode sweeps.
// Assumes the register map and decode word layout of the package.
`timescale 1ns/10ps
module tb_fit_decoder;
    logic        clk, rst, awv, wv, bry, arv, rry; // Clock, reset, handshakes.
    logic [7:0]  awa, ara;                         // Bus addresses.
    logic [31:0] wd, rd, dv;                       // Write, read, captured data.
    logic        awr, wr, bv, arr, rv;             // Slave handshakes.
    logic [1:0]  br, rr, rs, len;                  // Responses and length.
    logic [3:0]  cyc;                              // Cycle count output.
    logic [4:0]  idx;                              // Table index.
    logic [19:0] ent;                              // Current table word.
    int          err_total, checked;               // Tallies.
    fit_prog_rom u_rom (.addr_in(idx), .word_out(ent));
    fit_decoder u_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
        .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr),
        .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rry), .CYCLES_OUT(cyc), .LENGTH_OUT(len));
    // 50 ns clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Compare and tally.
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // Write; each channel is released at its own handshake edge.
    task automatic wr_t(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!(bv && !awv && !wv));
        r = br;
        bry <= 1'b0;
    endtask
    // Read; rready stays high until rvalid is seen.
    task automatic rd_t(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        d = rd;
        r = rr;
        rry <= 1'b0;
    endtask
    // Verdict, reached from the tests or the watchdog.
    task automatic final_report();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: the tests need well under 5000 cycles.
    initial begin
        #500000;
        err_total++;
        final_report();
    end
    // Test sequence.
    initial begin
        {rst, awv, wv, bry, arv, rry, awa, ara, wd, idx} = {1'b1, 58'h0};
        err_total = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("rst_cyc", cyc, 32'h2);
        rd_t(8'he0, dv, rs);
        chk("acc_rst", dv, 32'h0);
        rd_t(8'hf0, dv, rs);
        chk("b_rst", dv, 32'h0);
        wr_t(8'he0, 32'h5a, rs);
        chk("wr_ok", rs, fit_pkg::RESP_OKAY);
        wr_t(8'hf0, 32'ha5, rs);
        rd_t(8'he0, dv, rs);
        chk("acc_rw", dv, 32'h5a);
        chk("rd_ok", rs, fit_pkg::RESP_OKAY);
        rd_t(8'hf0, dv, rs);
        chk("b_rw", dv, 32'ha5);
        wr_t(8'h40, 32'h0, rs);
        chk("wr_bad", rs, fit_pkg::RESP_SLVERR);
        rd_t(8'h40, dv, rs);
        chk("rd_bad", rs, fit_pkg::RESP_SLVERR);
        // Opcode table sweep with the branch outcome set first.
        for (int i = 0; i < 22; i++) begin
            idx <= i[4:0];
            @(posedge clk);
            wr_t(8'h04, {31'h0, ent[8]}, rs);
            wr_t(8'h00, {24'h0, ent[19:12]}, rs);
            rd_t(8'h08, dv, rs);
            chk("dec_len", dv[1:0], ent[5:4]);
            chk("dec_cyc", dv[7:4], ent[3:0]);
            chk("out_cyc", cyc, ent[3:0]);
            chk("out_len", len, ent[5:4]);
        end
        chk("clr_bit", dv[17], 32'h1);
        // Register number and absolute page fields.
        for (int k = 0; k < 16; k++) begin
            wr_t(8'h00, {24'h0, k[2:0], k[3] ? 5'h11 : 5'h01}, rs);
            rd_t(8'h08, dv, rs);
            chk("abs_page", dv[15:12], {1'b1, k[2:0]});
            wr_t(8'h00, {24'h0, 5'h1d, k[2:0]}, rs);
            rd_t(8'h08, dv, rs);
            chk("reg_no", dv[11:8], {1'b1, k[2:0]});
        end
        // Read back the held opcode, the last branch outcome and the write count.
        rd_t(8'h00, dv, rs);
        chk("op_rb", dv, 32'hef);
        rd_t(8'h04, dv, rs);
        chk("cond_rb", dv, 32'h1);
        rd_t(8'h0c, dv, rs);
        chk("op_count", dv, 32'h36);
        final_report();
    end
endmodule
